// ---- pkg/jtpi_pkg.sv ----
// Constants and types of the test-port programming block
package jtpi_pkg;
    // Instruction register
    localparam int unsigned IR_W          = 4;
    localparam logic [3:0]  IR_CAPTURE    = 4'h1;
    localparam logic [3:0]  IR_RESET_VAL  = 4'hf;
    localparam logic [3:0]  KEY_INSTR     = 4'h4;
    localparam logic [3:0]  CMD_INSTR     = 4'h5;
    localparam logic [3:0]  FILL_INSTR    = 4'h6;
    localparam logic [3:0]  FETCH_INSTR   = 4'h7;
    localparam logic [3:0]  HOLD_INSTR    = 4'hc;
    // Data register widths
    localparam int unsigned KEY_W         = 16;
    localparam int unsigned CMD_W         = 15;
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned PAGE_BITS     = 1024;
    localparam int unsigned FETCH_EXTRA   = 8;
    localparam int unsigned CNT_W         = 11;
    // Programming enable signature
    localparam logic [15:0] KEY_SIG       = 16'ha370;
    localparam logic [15:0] KEY_RESET     = 16'h0000;
    // Result word position of the done flag during polling
    localparam int unsigned DONE_BIT      = 9;
    // Post-release hold, in core clock cycles
    localparam int unsigned TOUT_W        = 16;
    localparam logic [15:0] TOUT_RESET    = 16'h0000;
    // TAP controller states
    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } jtpi_tap_e;
endpackage

// ---- rtl/jtpi_port.sv ----
// Test-port programming logic: TAP, key, command, page fill and page fetch chains
////////////////////////////////////////////////////////////////////////////////
module jtpi_port
    import jtpi_pkg::*;
#(
    parameter int unsigned PAGE_W = PAGE_BITS,
    parameter int unsigned TOUT0  = 16,
    parameter int unsigned TOUT1  = 64,
    parameter int unsigned TOUT2  = 256,
    parameter int unsigned TOUT3  = 1024
) (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              arst_n_in,
    // Test port pins
    input  wire logic              tck_in,
    input  wire logic              tms_in,
    input  wire logic              tdi_in,
    output logic                   tdo_out,
    output logic                   tdo_oe_out,
    // Core reset control
    input  wire logic [1:0]        clk_opt_in,
    output logic                   core_hold_out,
    output logic                   prog_mode_out,
    // Command path to the memory array
    output logic [CMD_W-1:0]       cmd_word_out,
    output logic                   cmd_apply_out,
    output logic                   cmd_exec_out,
    input  wire logic [CMD_W-1:0]  result_in,
    input  wire logic              done_in,
    // Page fill stream
    output logic [BYTE_W-1:0]      fill_data_out,
    output logic                   fill_valid_out,
    input  wire logic              fill_ready_in,
    output logic                   fill_overrun_out,
    // Page fetch stream
    input  wire logic [BYTE_W-1:0] fetch_data_in,
    input  wire logic              fetch_valid_in,
    output logic                   fetch_ready_out
);
    // Sizes the counters cannot serve are refused at elaboration
    if (PAGE_W % BYTE_W != 0 || PAGE_W == 0
        || PAGE_W + FETCH_EXTRA >= (1 << CNT_W)) begin
        $error("jtpi_port: PAGE_W must be a nonzero multiple of 8 below 2040");
    end
    if (TOUT3 >= (1 << TOUT_W) || TOUT2 >= (1 << TOUT_W)
        || TOUT1 >= (1 << TOUT_W) || TOUT0 >= (1 << TOUT_W)) begin
        $error("jtpi_port: time-out counts must fit 16 bits");
    end

    localparam logic [CNT_W-1:0] FILL_LAST  = CNT_W'(PAGE_W - 1);
    localparam logic [CNT_W-1:0] FETCH_LAST = CNT_W'(PAGE_W + FETCH_EXTRA - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; sync_* stage 1 feeds only stage 2
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic       tck_d;
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            sync_a <= 3'h0;
            sync_b <= 3'h0;
            tck_d  <= 1'b0;
        end else begin
            sync_a <= {tck_in, tms_in, tdi_in};
            sync_b <= sync_a;
            tck_d  <= sync_b[2];
        end
    end

    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_rise;
    logic tck_fall;
    assign tck_s    = sync_b[2];
    assign tms_s    = sync_b[1];
    assign tdi_s    = sync_b[0];
    assign tck_rise = tck_s & ~tck_d;
    assign tck_fall = ~tck_s & tck_d;

    ////////////////////////////////////////////////////////////////////////////
    // TAP controller and instruction register
    jtpi_tap_e       tap;
    jtpi_tap_e       next_tap;
    logic [IR_W-1:0] ir;
    logic [IR_W-1:0] next_ir;
    logic [IR_W-1:0] ir_sr;
    logic [IR_W-1:0] next_ir_sr;

    // Standard 16-state walk on each sampled TCK rise
    always_comb begin
        next_tap   = tap;
        next_ir    = ir;
        next_ir_sr = ir_sr;
        if (tck_rise) begin
            unique case (tap)
                TAP_RESET:    next_tap = tms_s ? TAP_RESET    : TAP_IDLE;
                TAP_IDLE:     next_tap = tms_s ? TAP_SEL_DR   : TAP_IDLE;
                TAP_SEL_DR:   next_tap = tms_s ? TAP_SEL_IR   : TAP_CAP_DR;
                TAP_CAP_DR:   next_tap = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
                TAP_SHIFT_DR: next_tap = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
                TAP_EXIT1_DR: next_tap = tms_s ? TAP_UPD_DR   : TAP_PAUSE_DR;
                TAP_PAUSE_DR: next_tap = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
                TAP_EXIT2_DR: next_tap = tms_s ? TAP_UPD_DR   : TAP_SHIFT_DR;
                TAP_UPD_DR:   next_tap = tms_s ? TAP_SEL_DR   : TAP_IDLE;
                TAP_SEL_IR:   next_tap = tms_s ? TAP_RESET    : TAP_CAP_IR;
                TAP_CAP_IR:   next_tap = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
                TAP_SHIFT_IR: next_tap = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
                TAP_EXIT1_IR: next_tap = tms_s ? TAP_UPD_IR   : TAP_PAUSE_IR;
                TAP_PAUSE_IR: next_tap = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
                TAP_EXIT2_IR: next_tap = tms_s ? TAP_UPD_IR   : TAP_SHIFT_IR;
                TAP_UPD_IR:   next_tap = tms_s ? TAP_SEL_DR   : TAP_IDLE;
            endcase
            if (tap == TAP_CAP_IR)
                next_ir_sr = IR_CAPTURE;
            if (tap == TAP_SHIFT_IR)
                next_ir_sr = {tdi_s, ir_sr[IR_W-1:1]};
            if (tap == TAP_UPD_IR)
                next_ir = ir_sr;
            if (tap == TAP_RESET)
                next_ir = IR_RESET_VAL;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tap   <= TAP_RESET;
            ir    <= IR_RESET_VAL;
            ir_sr <= IR_CAPTURE;
        end else begin
            tap   <= next_tap;
            ir    <= next_ir;
            ir_sr <= next_ir_sr;
        end
    end

    // Decoded action strobes, each one sampled TCK rise wide
    logic in_shift;
    logic in_cap;
    logic in_upd;
    assign in_shift = tck_rise && tap == TAP_SHIFT_DR;
    assign in_cap   = tck_rise && tap == TAP_CAP_DR;
    assign in_upd   = tck_rise && tap == TAP_UPD_DR;

    ////////////////////////////////////////////////////////////////////////////
    // Data registers and command path
    logic [KEY_W-1:0]  key;
    logic [KEY_W-1:0]  next_key;
    logic              prog;
    logic              next_prog;
    logic [CMD_W-1:0]  cmd_sr;
    logic [CMD_W-1:0]  next_cmd_sr;
    logic [CMD_W-1:0]  cmd;
    logic [CMD_W-1:0]  next_cmd;
    logic              apply;
    logic              next_apply;
    logic              exec;
    logic              next_exec;
    logic              hold_bit;
    logic              next_hold_bit;
    logic              byp;
    logic              next_byp;
    logic [BYTE_W-1:0] pg_sr;
    logic [BYTE_W-1:0] next_pg_sr;
    logic [CNT_W-1:0]  bit_cnt;
    logic [CNT_W-1:0]  next_bit_cnt;
    logic              pend;
    logic              next_pend;
    logic [BYTE_W-1:0] pend_data;
    logic [BYTE_W-1:0] next_pend_data;
    logic              ovr;
    logic              next_ovr;
    logic              take;
    logic              next_take;
    logic              tdo;
    logic              next_tdo;
    logic              oe;
    logic              next_oe;
    logic              buf_ready;
    logic              push;

    assign push = pend & buf_ready;

    always_comb begin
        next_key       = key;
        next_prog      = prog;
        next_cmd_sr    = cmd_sr;
        next_cmd       = cmd;
        next_apply     = 1'b0;
        next_exec      = 1'b0;
        next_hold_bit  = hold_bit;
        next_byp       = byp;
        next_pg_sr     = pg_sr;
        next_bit_cnt   = bit_cnt;
        next_pend      = pend & ~buf_ready;
        next_pend_data = pend_data;
        next_ovr       = ovr;
        next_take      = 1'b0;
        next_tdo       = tdo;
        next_oe        = oe;
        if (tck_rise && tap == TAP_UPD_IR) begin
            next_bit_cnt = '0;
            next_pg_sr   = '0;
            next_ovr     = 1'b0;
        end
        if (tck_rise && tap == TAP_IDLE && ir == CMD_INSTR && prog)
            next_exec = 1'b1;
        unique case (ir)
            KEY_INSTR: begin
                if (in_shift)
                    next_key = {tdi_s, key[KEY_W-1:1]};
                if (in_upd)
                    next_prog = (key == KEY_SIG);
            end
            CMD_INSTR: begin
                if (in_cap) begin
                    next_cmd_sr           = result_in;
                    next_cmd_sr[DONE_BIT] = done_in;
                end
                if (in_shift)
                    next_cmd_sr = {tdi_s, cmd_sr[CMD_W-1:1]};
                if (in_upd && prog) begin
                    next_cmd   = cmd_sr;
                    next_apply = 1'b1;
                end
            end
            FILL_INSTR: begin
                // No update transfer: bytes leave as they complete
                if (in_cap)
                    next_bit_cnt = '0;
                if (in_shift && prog && bit_cnt <= FILL_LAST) begin
                    next_pg_sr   = {tdi_s, pg_sr[BYTE_W-1:1]};
                    next_bit_cnt = bit_cnt + CNT_W'(1);
                    if (bit_cnt[2:0] == 3'h7) begin
                        // A byte still waiting is overwritten; flagged for the host
                        next_ovr       = ovr | (pend & ~buf_ready);
                        next_pend      = 1'b1;
                        next_pend_data = {tdi_s, pg_sr[BYTE_W-1:1]};
                    end
                end
            end
            FETCH_INSTR: begin
                // No capture load; first byte out is the eight padding bits
                if (in_shift && prog && bit_cnt <= FETCH_LAST) begin
                    next_pg_sr   = {1'b0, pg_sr[BYTE_W-1:1]};
                    next_bit_cnt = bit_cnt + CNT_W'(1);
                    if (bit_cnt[2:0] == 3'h7 && bit_cnt != FETCH_LAST) begin
                        next_pg_sr = fetch_valid_in ? fetch_data_in : '0;
                        next_take  = 1'b1;
                    end
                end
            end
            HOLD_INSTR: begin
                if (in_shift)
                    next_hold_bit = tdi_s;
            end
            default: begin
                if (in_cap)
                    next_byp = 1'b0;
                if (in_shift)
                    next_byp = tdi_s;
            end
        endcase
        // TDO changes on the falling TCK edge, from the chain's low bit
        if (tck_fall) begin
            next_oe = (tap == TAP_SHIFT_DR) || (tap == TAP_SHIFT_IR);
            if (tap == TAP_SHIFT_IR)
                next_tdo = ir_sr[0];
            else
                unique case (ir)
                    KEY_INSTR:   next_tdo = key[0];
                    CMD_INSTR:   next_tdo = cmd_sr[0];
                    FILL_INSTR:  next_tdo = pg_sr[0];
                    FETCH_INSTR: next_tdo = pg_sr[0];
                    HOLD_INSTR:  next_tdo = hold_bit;
                    default:     next_tdo = byp;
                endcase
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            key       <= KEY_RESET;
            prog      <= 1'b0;
            cmd_sr    <= '0;
            cmd       <= '0;
            apply     <= 1'b0;
            exec      <= 1'b0;
            hold_bit  <= 1'b0;
            byp       <= 1'b0;
            pg_sr     <= '0;
            bit_cnt   <= '0;
            pend      <= 1'b0;
            pend_data <= '0;
            ovr       <= 1'b0;
            take      <= 1'b0;
            tdo       <= 1'b0;
            oe        <= 1'b0;
        end else begin
            key       <= next_key;
            prog      <= next_prog;
            cmd_sr    <= next_cmd_sr;
            cmd       <= next_cmd;
            apply     <= next_apply;
            exec      <= next_exec;
            hold_bit  <= next_hold_bit;
            byp       <= next_byp;
            pg_sr     <= next_pg_sr;
            bit_cnt   <= next_bit_cnt;
            pend      <= next_pend;
            pend_data <= next_pend_data;
            ovr       <= next_ovr;
            take      <= next_take;
            tdo       <= next_tdo;
            oe        <= next_oe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry page fill buffer; head drives the outputs directly
    logic              hd_v;
    logic              next_hd_v;
    logic [BYTE_W-1:0] hd_d;
    logic [BYTE_W-1:0] next_hd_d;
    logic              tl_v;
    logic              next_tl_v;
    logic [BYTE_W-1:0] tl_d;
    logic [BYTE_W-1:0] next_tl_d;

    assign buf_ready = ~tl_v;

    always_comb begin
        next_hd_v = hd_v;
        next_hd_d = hd_d;
        next_tl_v = tl_v;
        next_tl_d = tl_d;
        if (hd_v && fill_ready_in) begin
            next_hd_v = tl_v;
            next_hd_d = tl_d;
            next_tl_v = 1'b0;
        end
        if (push) begin
            if (!next_hd_v) begin
                next_hd_v = 1'b1;
                next_hd_d = pend_data;
            end else begin
                next_tl_v = 1'b1;
                next_tl_d = pend_data;
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hd_v <= 1'b0;
            hd_d <= '0;
            tl_v <= 1'b0;
            tl_d <= '0;
        end else begin
            hd_v <= next_hd_v;
            hd_d <= next_hd_d;
            tl_v <= next_tl_v;
            tl_d <= next_tl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core hold: chain bit acts at once, then a time-out by clock option
    logic [TOUT_W-1:0] tout;
    logic [TOUT_W-1:0] next_tout;
    logic              hold;
    logic              next_hold;
    logic [TOUT_W-1:0] tout_sel;

    always_comb begin
        unique case (clk_opt_in)
            2'h0: tout_sel = TOUT_W'(TOUT0);
            2'h1: tout_sel = TOUT_W'(TOUT1);
            2'h2: tout_sel = TOUT_W'(TOUT2);
            2'h3: tout_sel = TOUT_W'(TOUT3);
        endcase
    end

    always_comb begin
        next_tout = tout;
        if (next_hold_bit)
            next_tout = tout_sel;
        else if (tout != '0)
            next_tout = tout - TOUT_W'(1);
        next_hold = next_hold_bit | (tout != '0);
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            tout <= TOUT_RESET;
            hold <= 1'b0;
        end else begin
            tout <= next_tout;
            hold <= next_hold;
        end
    end

    // Outputs, each straight from a flip-flop
    assign tdo_out          = tdo;
    assign tdo_oe_out       = oe;
    assign core_hold_out    = hold;
    assign prog_mode_out    = prog;
    assign cmd_word_out     = cmd;
    assign cmd_apply_out    = apply;
    assign cmd_exec_out     = exec;
    assign fill_data_out    = hd_d;
    assign fill_valid_out   = hd_v;
    assign fill_overrun_out = ovr;
    assign fetch_ready_out  = take;
endmodule

// ---- sim/jtpi_port_assertions.sv ----
// Concurrent checks on the ports of the test-port programming block
module jtpi_port_assertions
    import jtpi_pkg::*;
#(
    parameter int unsigned TOUT0 = 16,
    parameter int unsigned TOUT1 = 64,
    parameter int unsigned TOUT2 = 256,
    parameter int unsigned TOUT3 = 1024
) (
    // Clock and reset
    input wire logic              clk_in,
    input wire logic              arst_n_in,
    // Observed ports
    input wire logic              tdo_oe_out,
    input wire logic [1:0]        clk_opt_in,
    input wire logic              core_hold_out,
    input wire logic              prog_mode_out,
    input wire logic [CMD_W-1:0]  cmd_word_out,
    input wire logic              cmd_apply_out,
    input wire logic              cmd_exec_out,
    input wire logic [BYTE_W-1:0] fill_data_out,
    input wire logic              fill_valid_out,
    input wire logic              fill_ready_in,
    input wire logic              fill_overrun_out,
    input wire logic              fetch_ready_out
);
    timeunit 1ns;
    timeprecision 1ns;

    default clocking dcb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    logic [11:0] hold_cnt;
    logic [11:0] next_hold_cnt;
    logic [11:0] tout_sel;

    // Length of the current core hold; wraps after 4095 cycles, fine for short holds
    always_comb begin
        next_hold_cnt = core_hold_out ? hold_cnt + 12'h001 : 12'h000;
        tout_sel = clk_opt_in[1] ? (clk_opt_in[0] ? 12'(TOUT3) : 12'(TOUT2))
                                 : (clk_opt_in[0] ? 12'(TOUT1) : 12'(TOUT0));
    end

    // Register the hold length
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            hold_cnt <= 12'h000;
        end else begin
            hold_cnt <= next_hold_cnt;
        end
    end

    // Port relations
    chk_apply_in_mode: assert property (cmd_apply_out |-> prog_mode_out)
        else $error("command applied outside programming mode");
    chk_exec_in_idle: assert property (cmd_exec_out |-> prog_mode_out && !tdo_oe_out)
        else $error("command executed while shifting or locked");
    chk_word_on_apply: assert property (!$stable(cmd_word_out) |-> cmd_apply_out)
        else $error("command word changed without apply pulse");
    chk_fill_stall: assert property (
        fill_valid_out && !fill_ready_in |=> fill_valid_out && $stable(fill_data_out))
        else $error("fill byte changed during stall");
    chk_overrun_full: assert property ($rose(fill_overrun_out) |-> fill_valid_out)
        else $error("overrun flagged with empty buffer");
    chk_fetch_gap: assert property (fetch_ready_out |=> !fetch_ready_out [*8])
        else $error("page bytes taken faster than one per byte");
    chk_hold_timeout: assert property ($fell(core_hold_out) |-> hold_cnt > tout_sel)
        else $error("core released before time-out");
    chk_key_update: assert property ($rose(prog_mode_out) |-> !tdo_oe_out)
        else $error("programming mode entered outside update");

    // Main scenarios
    cov_exec: cover property (cmd_exec_out);
    cov_key: cover property ($rose(prog_mode_out));
    cov_drain: cover property (fill_valid_out && fill_ready_in);
endmodule

bind jtpi_port jtpi_port_assertions #(.TOUT0(TOUT0), .TOUT1(TOUT1), .TOUT2(TOUT2), .TOUT3(TOUT3))
    u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in), .tdo_oe_out(tdo_oe_out),
    .clk_opt_in(clk_opt_in), .core_hold_out(core_hold_out), .prog_mode_out(prog_mode_out),
    .cmd_word_out(cmd_word_out), .cmd_apply_out(cmd_apply_out), .cmd_exec_out(cmd_exec_out),
    .fill_data_out(fill_data_out), .fill_valid_out(fill_valid_out),
    .fill_ready_in(fill_ready_in), .fill_overrun_out(fill_overrun_out),
    .fetch_ready_out(fetch_ready_out));

// ---- sim/jtpi_prog_model.sv ----
// External test-port programmer: walks the TAP and shifts chains LSB first
module jtpi_prog_model (
    // Test port pins; TCK rests low between frames
    output logic      tck_out = 1'b0,
    output logic      tms_out = 1'b1,
    output logic      tdi_out = 1'b0,
    input  wire logic tdo_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // One TCK period; TDO is taken at the rise, a full half period after the fall
    task automatic bit_clk(input logic tms, input logic tdi, output logic tdo);
        tms_out = tms;
        tdi_out = tdi;
        #400;
        tck_out = 1'b1;
        tdo = tdo_in;
        #400;
        tck_out = 1'b0;
    endtask

    // TMS walk with TDI low, sequence taken LSB first
    task automatic walk(input logic [7:0] seq, input int n);
        logic d;
        for (int i = 0; i < n; i++) begin
            bit_clk(seq[i], 1'b0, d);
        end
    endtask

    // Idle to Shift-IR, code, then Update-IR back to Idle
    task automatic shift_ir(input logic [3:0] code);
        logic d;
        walk(8'h03, 4);
        for (int i = 0; i < 4; i++) begin
            bit_clk(i == 3, code[i], d);
        end
        walk(8'h01, 2);
    endtask

    // Sole device on the chain, so fill and fetch chains are used directly
    task automatic shift_dr(input int n, input logic [1031:0] din, output logic [1031:0] dout);
        dout = '0;
        walk(8'h01, 3);
        for (int i = 0; i < n; i++) begin
            bit_clk(i == n - 1, din[i], dout[i]);
        end
        walk(8'h01, 2);
    endtask
endmodule

// ---- sim/jtpi_port_tb.sv ----
// Self-checking bench for the test-port programming block
module jtpi_port_tb
    import jtpi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [31:0] PAGE_PAT = 32'hd4c3b2a1;
    logic [CMD_W-1:0]  cmds [21] = '{15'h2380, 15'h3180, 15'h3380, 15'h3380, 15'h3380,
        15'h2310, 15'h0712, 15'h0334, 15'h1356, 15'h1778, 15'h3700, 15'h7700, 15'h3700,
        15'h3500, 15'h2302, 15'h3200, 15'h3600, 15'h2311, 15'h3300, 15'h3100, 15'h2303};
    logic              clk_in = 1'b0;
    logic              arst_n_in = 1'b0;
    wire logic         tck_in, tms_in, tdi_in;
    logic              tdo_out, tdo_oe_out, core_hold_out, prog_mode_out, cmd_apply_out;
    logic              cmd_exec_out, done_in, fill_valid_out, fill_ready_in, fill_overrun_out;
    logic              fetch_valid_in, fetch_ready_out;
    logic [1:0]        clk_opt_in;
    logic [CMD_W-1:0]  cmd_word_out, result_in;
    logic [BYTE_W-1:0] fill_data_out, fetch_data_in;
    logic [1031:0]     dout;
    logic [7:0]        fill_q[$];
    int                err_total, compares, applies, execs, fidx;

    always #50 clk_in = ~clk_in;

    // Short time-outs keep the core hold scenario brief
    jtpi_port #(.TOUT0(4), .TOUT1(4), .TOUT2(4), .TOUT3(40)) DUT (
        .clk_in(clk_in), .arst_n_in(arst_n_in), .tck_in(tck_in), .tms_in(tms_in),
        .tdi_in(tdi_in), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .clk_opt_in(clk_opt_in),
        .core_hold_out(core_hold_out), .prog_mode_out(prog_mode_out),
        .cmd_word_out(cmd_word_out), .cmd_apply_out(cmd_apply_out),
        .cmd_exec_out(cmd_exec_out), .result_in(result_in), .done_in(done_in),
        .fill_data_out(fill_data_out), .fill_valid_out(fill_valid_out),
        .fill_ready_in(fill_ready_in), .fill_overrun_out(fill_overrun_out),
        .fetch_data_in(fetch_data_in), .fetch_valid_in(fetch_valid_in),
        .fetch_ready_out(fetch_ready_out));
    jtpi_prog_model prog (.tck_out(tck_in), .tms_out(tms_in), .tdi_out(tdi_in), .tdo_in(tdo_out));

    // Memory side: counts pulses, drains the fill stream, serves page bytes
    always @(posedge clk_in) begin
        if (cmd_apply_out === 1'b1) applies++;
        if (cmd_exec_out === 1'b1) execs++;
        if (fill_valid_out === 1'b1 && fill_ready_in === 1'b1) fill_q.push_back(fill_data_out);
        if (fetch_ready_out === 1'b1) fidx++;
    end
    always @(negedge clk_in) fetch_data_in <= PAGE_PAT[8 * fidx[1:0] +: 8];

    task automatic check(input logic [1031:0] seen, input logic [1031:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic stop_test;
        if (err_total == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Hold set, then released with the TAP untouched; release lags by the time-out
    task automatic t_hold;
        prog.walk(8'h1f, 6);
        prog.shift_ir(HOLD_INSTR);
        prog.shift_dr(1, 1032'h1, dout);
        check(core_hold_out, 1'b1, "core not held");
        prog.shift_dr(1, 1032'h0, dout);
        check(dout[0], 1'b1, "hold bit lost");
        check(core_hold_out, 1'b1, "hold released early");
        repeat (20) @(negedge clk_in);
        check(core_hold_out, 1'b1, "hold shorter than time-out");
        repeat (10) @(negedge clk_in);
        check(core_hold_out, 1'b0, "hold stuck");
        // Option 1 picks the short time-out, already over when the scan ends
        clk_opt_in = 2'h1;
        prog.shift_dr(1, 1032'h1, dout);
        prog.shift_dr(1, 1032'h0, dout);
        check(core_hold_out, 1'b0, "short hold stuck");
    endtask

    // Near-miss key first, exact key second; core was reset just before
    task automatic t_key;
        prog.shift_ir(KEY_INSTR);
        prog.shift_dr(KEY_W, 1032'ha371, dout);
        check(prog_mode_out, 1'b0, "near key accepted");
        prog.shift_dr(KEY_W, 1032'ha370, dout);
        check(prog_mode_out, 1'b1, "key refused");
    endtask

    // Every command word of the erase, write and read series, then idle clocks
    task automatic t_cmds;
        logic [CMD_W-1:0] exp;
        int a0;
        int e0;
        prog.shift_ir(CMD_INSTR);
        foreach (cmds[k]) begin
            result_in = ~cmds[k];
            done_in = k[0];
            exp = ~cmds[k];
            exp[DONE_BIT] = k[0];
            a0 = applies;
            prog.shift_dr(CMD_W, 1032'(cmds[k]), dout);
            check(dout[CMD_W-1:0], exp, "captured result");
            check(cmd_word_out, cmds[k], "applied word");
            check(applies - a0, 1, "apply count");
            e0 = execs;
            prog.walk(8'h00, 2);
            repeat (4) @(negedge clk_in);
            check(execs - e0, 2, "exec count");
        end
    endtask

    // Four bytes into a stalled buffer: the waiting third is overwritten and flagged
    task automatic t_fill;
        prog.shift_ir(FILL_INSTR);
        prog.shift_dr(32, 1032'h44332211, dout);
        check(fill_valid_out, 1'b1, "fill not offered");
        check(fill_overrun_out, 1'b1, "loss not flagged");
        fill_ready_in = 1'b1;
        repeat (10) @(negedge clk_in);
        fill_ready_in = 1'b0;
        check(fill_q.size(), 3, "fill count");
        check({fill_q[0], fill_q[1], fill_q[2]}, 24'h112244, "fill order");
        check(fill_valid_out, 1'b0, "fill not drained");
    endtask

    // Pad byte then page bytes LSB first, TDI held high throughout
    task automatic t_fetch;
        prog.shift_ir(FETCH_INSTR);
        check(fill_overrun_out, 1'b0, "overrun kept");
        fidx = 0;
        prog.shift_dr(40, '1, dout);
        check(dout[39:0], {PAGE_PAT, 8'h00}, "fetch stream");
    endtask

    // Programmer clears the key on leaving; commands are then refused
    task automatic t_exit;
        int a0;
        prog.shift_ir(KEY_INSTR);
        prog.shift_dr(KEY_W, 1032'h0, dout);
        check(prog_mode_out, 1'b0, "mode kept");
        prog.shift_ir(CMD_INSTR);
        a0 = applies;
        prog.shift_dr(CMD_W, 1032'h2380, dout);
        check(applies - a0, 0, "command without key");
    endtask

    // Main sequence
    initial begin
        clk_opt_in = 2'h3;
        result_in = '0;
        done_in = 1'b0;
        fill_ready_in = 1'b0;
        fetch_valid_in = 1'b1;
        fetch_data_in = 8'h00;
        repeat (3) @(negedge clk_in);
        arst_n_in = 1'b1;
        @(negedge clk_in);
        check(prog_mode_out, 1'b0, "mode at reset");
        t_hold();
        t_key();
        t_cmds();
        t_fill();
        t_fetch();
        t_exit();
        stop_test();
    end

    // Watchdog: about two and a half times the expected run
    initial begin
        #1500000;
        err_total++;
        stop_test();
    end
endmodule
